// [hw/i2c_seq_map.svh]
`ifndef I2C_SEQ_MAP_SVH
`define I2C_SEQ_MAP_SVH

// ----------------------------------------------------------------
// apb register byte addresses
// ----------------------------------------------------------------
`define ADR_CTRL       8'h00
`define ADR_STAT       8'h04
`define ADR_MODE       8'h08
`define ADR_DATA       8'h0C
`define ADR_STC        8'h10
`define ADR_IST        8'h14
`define ADR_IMASK      8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_IEN       0
`define CTRL_TRS       1
`define CTRL_BUSY      2
`define CTRL_SCP       3
`define CTRL_FLAG      4
`define STAT_ACK       0
`define STAT_RRDY      1
`define MODE_WAIT      0
`define IRQ_EVT        0
`define IRQ_RRDY       1
`define IRQ_NACK       2
`define IRQ_W          3

// ----------------------------------------------------------------
// reset values, frame positions, timing
// ----------------------------------------------------------------
`define STC_RESET      8'h00
`define ACK_SLOT       4'h8
`define LAST_DATA_BIT  4'h7
`define PH_LOW         4'h0
`define PH_HIGH        4'h1
`define PH_REL         4'h2
`define CLK_MHZ        50
`define SCL_HALF_NS    80
`define SCL_HALF_CYC   ((`SCL_HALF_NS * `CLK_MHZ) / 1000)

`endif

// [hw/i2c_seq_pkg.sv]
`include "i2c_seq_map.svh"

package i2c_seq_pkg;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_START = 6'h02,
		ST_HOLD  = 6'h04,
		ST_LOW   = 6'h08,
		ST_HIGH  = 6'h10,
		ST_STOP  = 6'h20
	} bus_state_t;

	typedef struct packed {
		bus_state_t           fsm;
		logic [3:0]           div;
		logic [3:0]           bitn;
		logic [7:0]           sh;
		logic [7:0]           data;
		logic [7:0]           stc;
		logic [`IRQ_W-1:0]    ist;
		logic [`IRQ_W-1:0]    imask;
		logic [31:0]          prdata;
		logic                 ien;
		logic                 transmit_select;
		logic                 busy;
		logic                 start_stop_qualifier;
		logic                 flag;
		logic                 rrdy;
		logic                 ack_tx;
		logic                 ack_rx;
		logic                 wait_en;
		logic                 data_pend;
		logic                 frame_rx;
		logic                 scl_low;
		logic                 sda_low;
	} seq_state_t;

	typedef struct packed {
		logic                 scl1;
		logic                 scl2;
		logic                 sda1;
		logic                 sda2;
	} sync_state_t;

endpackage

// [hw/line_sync_if.sv]
`timescale 1ns/10ps

interface line_sync_if;
	logic scl;
	logic sda;
	modport drv (output scl, output sda);
	modport mon (input scl, input sda);
endinterface

// [hw/line_sync.sv]
`timescale 1ns/10ps

module line_sync
	import i2c_seq_pkg::*;
(
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst_n,
	// raw pin levels
	input  wire logic   scl_i,
	input  wire logic   sda_i,
	// synchronised levels
	line_sync_if.drv    sync
);

	sync_state_t q;
	sync_state_t d;

	// first stage feeds only the second stage
	always_comb begin
		d.scl1 = scl_i;
		d.scl2 = q.scl1;
		d.sda1 = sda_i;
		d.sda2 = q.sda1;
	end

	// released bus idles high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{scl1: 1'b1, scl2: 1'b1, sda1: 1'b1, sda2: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign sync.scl = q.scl2;
	assign sync.sda = q.sda2;

endmodule

// [hw/i2c_master_transfer_sequencer.sv]
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps

// Summary of operation
// R1: transmit frame captures receiver acknowledge level into ack_bit_value; 0 means acknowledged.
// R2: receive frame drives software ack_bit_value onto SDA in the acknowledge slot.
// R3: ack_bit_value reads captured level when transmit_select=1, written level otherwise.
// R4: writing ack_bit_value changes only the level to send; captured level stays.
// R5: each byte written to shift_data_reg is sent with its clock.
// R6: addressed slave pulls SDA low on the ninth clock to acknowledge.
// R7: transmit sets transfer_event_flag at rise of ninth clock.
// R8: after a transmit frame SCL stays low until the next byte is written.
// R9: software writes next byte and clears the flag back to back.
// R10: on no acknowledge software stops and retries, otherwise continues.
// R11: flag clear with bus_busy_bit and start_stop_qualifier zero produces stop condition.
// R12: receive with wait sets flag at fall of eighth clock, holds SCL low.
// R13: interrupt request when flag sets and event_irq_enable is one; here irq also needs imask bit IRQ_EVT set.
// R14: clearing the flag in wait releases ninth clock with acknowledge driven.
// R15: ninth-clock rise in receive sets flag and receive_ready_flag; clocking continues (here only with wait set, else SCL is held low until the flag is cleared).
// R16: software clears, reads and clears again within one byte time.
// R17: final byte: software sets ack 1, transmit_select 1, then clears flag.
// R18: software ends reception by clearing wait, reading, then clearing flag.
// R19: serial_timer_control resets to zero; reserved bit 7 never written with one.
module i2c_master_transfer_sequencer
	import i2c_seq_pkg::*;
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// two-wire bus pins, open drain
	input  wire logic          scl_i,
	output logic               scl_o,
	output logic               scl_oe,
	input  wire logic          sda_i,
	output logic               sda_o,
	output logic               sda_oe,
	// interrupt
	output logic               irq
);

	localparam seq_state_t SEQ_RESET = '{fsm: ST_IDLE, stc: `STC_RESET, default: '0}; // R19
	localparam logic [3:0] HALF_LAST = 4'(`SCL_HALF_CYC - 1);

	seq_state_t q;
	seq_state_t d;
	line_sync_if lines ();

	line_sync u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.scl_i (scl_i),
		.sda_i (sda_i),
		.sync  (lines.drv)
	);

	function automatic logic mapped(input logic [7:0] a);
		return a == `ADR_CTRL || a == `ADR_STAT || a == `ADR_MODE || a == `ADR_DATA ||
			a == `ADR_STC || a == `ADR_IST || a == `ADR_IMASK;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        wr_acc;
		logic        rd_ist;
		logic        half_done;
		logic        rise;
		logic        stall;
		logic        ev_flag;
		logic        ev_rrdy;
		logic        ev_nack;
		logic [31:0] rw;
		d         = q;
		wr_acc    = psel && penable && pwrite;
		rd_ist    = psel && penable && !pwrite && paddr == `ADR_IST;
		half_done = q.div == HALF_LAST;
		rise      = lines.scl && q.div == 4'h0;
		stall     = q.bitn == `ACK_SLOT && q.frame_rx && q.wait_en && q.flag;
		ev_flag   = 1'b0;
		ev_rrdy   = 1'b0;
		ev_nack   = 1'b0;
		rw        = 32'h0000_0000;

		// read word is latched in the setup phase
		unique case (paddr)
			`ADR_CTRL: begin
				rw[`CTRL_IEN]  = q.ien;
				rw[`CTRL_TRS]  = q.transmit_select;
				rw[`CTRL_BUSY] = q.busy;
				rw[`CTRL_SCP]  = q.start_stop_qualifier;
				rw[`CTRL_FLAG] = q.flag;
			end
			`ADR_STAT: begin
				rw[`STAT_ACK]  = q.transmit_select ? q.ack_rx : q.ack_tx; // R3
				rw[`STAT_RRDY] = q.rrdy;
			end
			`ADR_MODE:  rw[`MODE_WAIT] = q.wait_en;
			`ADR_DATA:  rw[7:0] = q.data;
			`ADR_STC:   rw[7:0] = q.stc;
			`ADR_IST:   rw[`IRQ_W-1:0] = q.ist;
			`ADR_IMASK: rw[`IRQ_W-1:0] = q.imask;
			default:    rw = 32'h0000_0000;
		endcase
		if (psel && !penable) begin
			d.prdata = rw;
		end

		// ------------------------------------------------------------
		// register writes, clears lose against same-cycle sets below
		// ------------------------------------------------------------
		if (wr_acc) begin
			unique case (paddr)
				`ADR_CTRL: begin
					d.ien = pwdata[`CTRL_IEN];
					d.transmit_select = pwdata[`CTRL_TRS];
					d.start_stop_qualifier = pwdata[`CTRL_SCP];
					if (!pwdata[`CTRL_SCP]) begin
						d.busy = pwdata[`CTRL_BUSY]; // R11
					end
					if (!pwdata[`CTRL_FLAG]) begin
						d.flag = 1'b0;
					end
				end
				`ADR_STAT: begin
					d.ack_tx = pwdata[`STAT_ACK]; // R4
					if (!pwdata[`STAT_RRDY]) begin
						d.rrdy = 1'b0;
					end
				end
				`ADR_MODE:  d.wait_en = pwdata[`MODE_WAIT];
				`ADR_DATA: begin
					d.data      = pwdata[7:0];
					d.data_pend = 1'b1;
				end
				`ADR_STC:   d.stc = pwdata[7:0];
				`ADR_IMASK: d.imask = pwdata[`IRQ_W-1:0];
				default:    d.stc = q.stc;
			endcase
		end

		// ------------------------------------------------------------
		// bit engine
		// ------------------------------------------------------------
		d.div = q.div + 4'h1;
		unique case (q.fsm)
			ST_IDLE: begin
				d.div     = 4'h0;
				d.scl_low = 1'b0;
				d.sda_low = 1'b0;
				if (q.busy) begin
					d.fsm     = ST_START;
					d.sda_low = 1'b1;
				end
			end
			ST_START: begin
				if (half_done) begin
					d.fsm     = ST_HOLD;
					d.scl_low = 1'b1;
					d.div     = 4'h0;
				end
			end
			ST_HOLD: begin
				d.div     = 4'h0;
				d.scl_low = 1'b1; // R8
				d.bitn    = 4'h0;
				if (!q.busy && !q.flag) begin
					d.fsm     = ST_STOP; // R11
					d.bitn    = `PH_LOW;
				end else if (q.transmit_select && q.data_pend) begin
					d.fsm       = ST_LOW; // R5
					d.sh        = q.data;
					d.data_pend = wr_acc && paddr == `ADR_DATA; // a byte written now is kept
					d.frame_rx  = 1'b0;
				end else if (!q.transmit_select && (!q.flag || q.wait_en)) begin
					d.fsm      = ST_LOW; // R15
					d.frame_rx = 1'b1;
				end
			end
			ST_LOW: begin
				// data moves one cycle after SCL fell
				if (q.frame_rx) begin
					d.sda_low = q.bitn == `ACK_SLOT && !q.ack_tx; // R2 R14
				end else begin
					d.sda_low = q.bitn != `ACK_SLOT && !q.sh[7]; // R5
				end
				if (stall) begin
					d.div = 4'h0; // R12
				end else if (half_done) begin
					d.fsm     = ST_HIGH; // R14
					d.scl_low = 1'b0;
					d.div     = 4'h0;
				end
			end
			ST_HIGH: begin
				// slave may stretch: count only while SCL is seen high
				d.div = lines.scl ? q.div + 4'h1 : q.div;
				if (rise && q.bitn == `ACK_SLOT) begin
					d.flag  = 1'b1; // R7 R15
					ev_flag = 1'b1;
					if (q.frame_rx) begin
						d.rrdy  = 1'b1; // R15
						d.data  = q.sh;
						ev_rrdy = 1'b1;
					end else begin
						d.ack_rx = lines.sda; // R1
						ev_nack  = lines.sda;
					end
				end else if (rise) begin
					d.sh = {q.sh[6:0], lines.sda};
				end
				if (lines.scl && half_done) begin
					d.scl_low = 1'b1;
					d.div     = 4'h0;
					if (q.bitn == `ACK_SLOT) begin
						d.fsm = ST_HOLD;
					end else begin
						d.fsm  = ST_LOW;
						d.bitn = q.bitn + 4'h1;
					end
					if (q.bitn == `LAST_DATA_BIT && q.frame_rx && q.wait_en) begin
						d.flag  = 1'b1; // R12
						ev_flag = 1'b1;
					end
				end
			end
			ST_STOP: begin
				if (q.bitn == `PH_LOW) begin
					d.sda_low = 1'b1;
					if (half_done) begin
						d.bitn    = `PH_HIGH;
						d.scl_low = 1'b0;
						d.div     = 4'h0;
					end
				end else if (q.bitn == `PH_HIGH) begin
					d.div = lines.scl ? q.div + 4'h1 : q.div;
					if (lines.scl && half_done) begin
						d.bitn    = `PH_REL;
						d.sda_low = 1'b0; // R11
						d.div     = 4'h0;
					end
				end else if (half_done) begin
					d.fsm = ST_IDLE;
				end
			end
			default: d.fsm = ST_IDLE;
		endcase

		// ------------------------------------------------------------
		// sticky interrupt status, cleared by reading it
		// ------------------------------------------------------------
		d.ist = rd_ist ? '0 : q.ist;
		d.ist[`IRQ_EVT]  = d.ist[`IRQ_EVT] | (ev_flag & q.ien); // R13
		d.ist[`IRQ_RRDY] = d.ist[`IRQ_RRDY] | ev_rrdy;
		d.ist[`IRQ_NACK] = d.ist[`IRQ_NACK] | ev_nack;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= SEQ_RESET;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata  = q.prdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign scl_o   = 1'b0;
	assign scl_oe  = q.scl_low;
	assign sda_o   = 1'b0;
	assign sda_oe  = q.sda_low;
	assign irq     = |(q.ist & q.imask); // R13

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic rise_seen;
	assign rise_seen = lines.scl && q.div == 4'h0;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_ack_read_mux: assert property ( // R3
		psel && !penable && paddr == `ADR_STAT
		|=> prdata[`STAT_ACK] == ($past(q.transmit_select) ? $past(q.ack_rx) : $past(q.ack_tx)))
		else $error("ack read does not follow transmit_select");
	a_ack_write_keep: assert property ( // R4
		psel && penable && pwrite && paddr == `ADR_STAT
		|=> q.ack_tx == $past(pwdata[`STAT_ACK]) && $stable(q.ack_rx))
		else $error("ack write disturbed captured level");
	a_tx_flag_rise: assert property ( // R7
		q.fsm == ST_HIGH && !q.frame_rx && q.bitn == `ACK_SLOT && rise_seen
		|=> q.flag && q.ack_rx == $past(lines.sda))
		else $error("flag or ack not set at ninth rise");
	a_hold_scl_low: assert property ( // R8
		q.fsm == ST_HOLD && q.transmit_select && !q.data_pend && q.busy |=> scl_oe && q.fsm == ST_HOLD)
		else $error("scl released without new byte");
	a_rx_wait_hold: assert property ( // R12
		q.fsm == ST_LOW && q.bitn == `ACK_SLOT && q.frame_rx && q.wait_en && q.flag
		&& !(psel && penable && pwrite) |=> (q.fsm == ST_LOW && scl_oe) [*2])
		else $error("wait did not hold scl low");
	a_ack_drive: assert property ( // R2
		q.fsm == ST_LOW && q.frame_rx && q.bitn == `ACK_SLOT && q.div == 4'h2
		|-> sda_oe == !q.ack_tx)
		else $error("ack slot level wrong");
	a_rrdy_flag: assert property ( // R15
		$rose(q.rrdy) |-> q.flag && q.fsm == ST_HIGH)
		else $error("receive ready without event flag");
	a_stop_edge: assert property ( // R11
		q.fsm == ST_STOP && $fell(sda_oe) |-> !scl_oe && lines.scl)
		else $error("stop edge not under high scl");
	a_irq_raise: assert property ( // R13
		$rose(q.flag) && $past(q.ien) && q.imask[`IRQ_EVT] |-> irq)
		else $error("event did not raise interrupt");

	c_tx_frame: cover property (q.fsm == ST_HIGH && !q.frame_rx ##1 q.fsm == ST_HOLD);
	c_rx_wait: cover property (q.fsm == ST_LOW && q.frame_rx && q.flag && q.wait_en);
	c_stop: cover property (q.fsm == ST_STOP ##1 q.fsm == ST_IDLE);
	c_irq: cover property ($rose(irq));

endmodule

// [dv/i2c_slave_model.sv]
`timescale 1ns/10ps

module i2c_slave_model (
	// bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	// behaviour
	input  wire logic       rx_mode,
	input  wire logic       ack_en,
	input  wire logic [7:0] tx_byte,
	// results
	output logic            pull,
	output logic      [7:0] got
);
	logic [3:0] n;
	logic [7:0] sh;

	initial begin
		n = 4'h0;
		sh = 8'h00;
		got = 8'h00;
	end

	// sda moving while scl is high is a start or stop: frame count restarts
	always @(sda) begin
		if (scl === 1'b1) n = 4'h0;
	end

	always @(negedge scl) begin
		n = (n == 4'h9) ? 4'h1 : n + 4'h1;
	end

	always @(posedge scl) begin
		if (n >= 4'h1 && n <= 4'h8) begin
			sh = {sh[6:0], sda};
			if (n == 4'h8) got = sh;
		end
	end

	// open drain only: a released line floats to the pull-up, no stale level
	always_comb begin
		if (rx_mode) pull = (n >= 4'h1 && n <= 4'h8) && !tx_byte[4'h8 - n];
		else pull = (n == 4'h9) && ack_en;
	end
endmodule

// [dv/tb_i2c_master_transfer_sequencer.sv]
`timescale 1ns/10ps
`include "i2c_seq_map.svh"

module tb_i2c_master_transfer_sequencer;
	typedef struct {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_t;

	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        scl_o;
	logic        scl_oe;
	logic        sda_o;
	logic        sda_oe;
	logic        irq;
	logic        pull;
	logic        rx_mode;
	logic        ack_en;
	logic [7:0]  got;
	logic [31:0] rd;
	logic        err;
	// released lines float to the pull-up level
	wire         scl_w = scl_oe ? scl_o : 1'b1;
	wire         sda_w = (sda_oe ? sda_o : 1'b1) & ~pull;
	int          failures;
	int          comparisons;
	row_t        rows [8] = '{
		'{`ADR_MODE, 32'h1, 32'h1}, '{`ADR_MODE, 32'h0, 32'h0},
		'{`ADR_STC, 32'h7F, 32'h7F}, '{`ADR_STC, 32'h0, 32'h0},
		'{`ADR_IMASK, 32'h7, 32'h7}, '{`ADR_IMASK, 32'h0, 32'h0},
		'{`ADR_STAT, 32'h1, 32'h1}, '{`ADR_STAT, 32'h0, 32'h0}
	};

	i2c_master_transfer_sequencer dut (
		.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
	);

	i2c_slave_model slave (
		.scl(scl_w), .sda(sda_w), .rx_mode(rx_mode), .ack_en(ack_en),
		.tx_byte(8'hC3), .pull(pull), .got(got)
	);

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic results;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic hang;
		failures++;
		$display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		results;
	endtask

	task automatic check_word(input logic [31:0] got_v, input logic [31:0] exp_v);
		comparisons++;
		if (got_v !== exp_v) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask

	task automatic check_bit(input logic got_v, input logic exp_v);
		check_word({31'h0, got_v}, {31'h0, exp_v});
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) hang;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_flag;
		int k;
		k = 0;
		do begin
			apb(1'b0, `ADR_CTRL, 32'h0);
			k++;
		end while (rd[`CTRL_FLAG] !== 1'b1 && k < 400);
		if (rd[`CTRL_FLAG] !== 1'b1) hang;
	endtask

	// sel 0 watches scl, 1 watches sda
	task automatic wait_line(input logic sel, input logic v);
		int k;
		k = 0;
		while ((sel ? sda_w : scl_w) !== v && k < 300) begin
			@(posedge clk);
			k++;
		end
		if ((sel ? sda_w : scl_w) !== v) hang;
	endtask

	task automatic hold_low;
		int h;
		h = 0;
		repeat (40) begin
			@(posedge clk);
			if (scl_w !== 1'b0) h++;
		end
		check_word(32'(h), 32'h0);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx_mode = 1'b0;
		ack_en = 1'b1;
		failures = 0;
		comparisons = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check_bit(irq, 1'b0);
		apb(1'b0, `ADR_STC, 32'h0);
		check_word(rd, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].addr, rows[i].wdata);
			apb(1'b0, rows[i].addr, 32'h0);
			check_word(rd, rows[i].exp);
		end
		apb(1'b0, 8'h1C, 32'h0);
		check_bit(err, 1'b1);
		// transmit, acknowledged, event masked at first
		apb(1'b1, `ADR_CTRL, 32'h7);
		apb(1'b1, `ADR_DATA, 32'hA5);
		wait_flag;
		check_word({24'h0, got}, 32'hA5);
		check_bit(irq, 1'b0);
		apb(1'b0, `ADR_STAT, 32'h0);
		check_bit(rd[`STAT_ACK], 1'b0);
		hold_low;
		apb(1'b1, `ADR_IMASK, 32'h1);
		check_bit(irq, 1'b1);
		apb(1'b0, `ADR_IST, 32'h0);
		check_word(rd, 32'h1);
		check_bit(irq, 1'b0);
		// refused byte, then stop
		ack_en <= 1'b0;
		apb(1'b1, `ADR_DATA, 32'h3C);
		apb(1'b1, `ADR_CTRL, 32'hB);
		wait_flag;
		apb(1'b1, `ADR_STAT, 32'h0);
		apb(1'b0, `ADR_STAT, 32'h0);
		check_bit(rd[`STAT_ACK], 1'b1);
		apb(1'b1, `ADR_CTRL, 32'h3);
		wait_line(1'b1, 1'b0);
		wait_line(1'b1, 1'b1);
		check_bit(scl_w, 1'b1);
		// receive with wait
		ack_en <= 1'b1;
		repeat (8) @(posedge clk);
		apb(1'b1, `ADR_MODE, 32'h1);
		apb(1'b1, `ADR_CTRL, 32'h7);
		apb(1'b1, `ADR_DATA, 32'hA1);
		wait_flag;
		rx_mode <= 1'b1;
		apb(1'b1, `ADR_CTRL, 32'h9);
		wait_flag;
		hold_low;
		apb(1'b1, `ADR_CTRL, 32'h9);
		wait_line(1'b0, 1'b1);
		check_bit(sda_w, 1'b0);
		wait_flag;
		apb(1'b0, `ADR_STAT, 32'h0);
		check_bit(rd[`STAT_RRDY], 1'b1);
		apb(1'b0, `ADR_DATA, 32'h0);
		check_word(rd, 32'hC3);
		apb(1'b1, `ADR_CTRL, 32'h9);
		wait_flag;
		apb(1'b1, `ADR_STAT, 32'h1);
		apb(1'b1, `ADR_CTRL, 32'hB);
		wait_line(1'b0, 1'b1);
		check_bit(sda_w, 1'b1);
		wait_flag;
		apb(1'b0, `ADR_STAT, 32'h0);
		check_bit(rd[`STAT_ACK], 1'b0);
		apb(1'b1, `ADR_MODE, 32'h0);
		apb(1'b0, `ADR_DATA, 32'h0);
		check_word(rd, 32'hC3);
		apb(1'b1, `ADR_CTRL, 32'h3);
		wait_line(1'b1, 1'b0);
		wait_line(1'b1, 1'b1);
		check_bit(scl_w, 1'b1);
		results;
	end
endmodule
